// ### asy_core.sv
// Asynchronous serial transmitter and receiver with register port
`default_nettype none
`include "asy_defines.svh"

// Notes on behaviour
// - Baud generator runs from the link clock, which is CLK_SYS here.
// - Output idles high; transmit invert flips every transmitted level.
// - Enabling the transmitter queues one idle frame, then waits for data.
// - Shifter holds 10 bits in eight-bit mode, 11 in nine-bit mode.
// - Free shifter takes waiting character on a bit tick; buffer-empty then sets.
// - Nothing waiting after a stop bit: set done flag, idle high.
// - Clearing transmit enable keeps the pin until the frame being shifted and any queued idle or break end; a waiting character is not sent.
// - Break request written 1 then 0 queues one all-zero break frame.
// - Break request still 1 when a break loads queues another one.
// - Break lasts 10, 11, 13 or 14 bit times by long-break and nine-bit.
// - Transmit enable written 0 then 1 queues one idle frame.
// - Receive invert flips input level; receive enable activates the receiver.
// - Frame: start 0, eight or nine data bits LSB first, stop 1.
// - Received character goes to empty buffer; full buffer gives overrun, data lost.
// - Sampling at 16x baud; falling edge is a 0 after three 1s.
// - Start accepted only if two of phases 3, 5, 7 read 0.
// - Bits decided by majority at phases 8, 9, 10; start stays 0.
// - Any sample disagreeing with its bit sets noise on transfer.
// - Edges keep being searched during reception and realign the phase.
// - Framing error on a non-break preloads three 1s into edge history.
// - While framing error flag is set, no character enters the buffer.
// - Receive-full clears by a two-step software access, never by write.
// - The two steps are status read with flag 1, then data read.
module asy_core
    import asy_pkg::*;
#(
    parameter int BAUD_W = 13
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic RXD_IN,
    output logic TXD_OUT,
    output logic TXD_OE_N
);
    logic [BAUD_W-1:0] div_r, cnt_r;
    logic [3:0] sub_r;
    logic nine_r, lbrk_r, tx_level_invert_r, rx_level_invert_r, tx_on_r, rx_on_r, brk_req_r, t8_r;
    logic [8:0] tx_buf_r;
    logic tx_full_r, tc_r, pend_idle_r, pend_brk_r;
    logic [13:0] shift_r;
    logic [3:0] left_r;
    asy_rx_state_t rx_st_r;
    logic [2:0] hist_r;
    logic [4:0] phase_r;
    logic [3:0] bitn_r;
    logic [1:0] smp_r;
    logic [8:0] rsh_r, rx_buf_r;
    logic noise_r, rx_buffer_full_r, or_r, nf_r, fe_r, arm_r;
    logic [7:0] rdata_r;

    // Register decode
    wire wr_hi = WR && ADDR == `ASY_OFF_BAUD_HI;
    wire wr_lo = WR && ADDR == `ASY_OFF_BAUD_LO;
    wire wr_c1 = WR && ADDR == `ASY_OFF_CTRL1;
    wire wr_c2 = WR && ADDR == `ASY_OFF_CTRL2;
    wire wr_c3 = WR && ADDR == `ASY_OFF_CTRL3;
    wire wr_data = WR && ADDR == `ASY_OFF_DATA;
    wire rd_stat = RD && ADDR == `ASY_OFF_STAT1;
    wire rd_data = RD && ADDR == `ASY_OFF_DATA;

    // Baud generation
    wire sample_tick = (div_r != '0) && (cnt_r <= BAUD_W'(1));
    wire bit_tick = sample_tick && sub_r == `ASY_SUB_LAST;

    // Transmitter
    wire [3:0] frame_len = nine_r ? `ASY_LEN_9 : `ASY_LEN_8;
    wire [3:0] brk_len = lbrk_r ? (nine_r ? `ASY_LEN_BRK14 : `ASY_LEN_LONG_BREAK_SELECT) : frame_len;
    wire shifter_free = bit_tick && left_r <= 4'h1;
    wire load_idle = shifter_free && pend_idle_r;
    wire load_brk = shifter_free && !pend_idle_r && pend_brk_r;
    wire load_data = shifter_free && !pend_idle_r && !pend_brk_r && tx_full_r && tx_on_r;
    wire any_load = load_idle || load_brk || load_data;
    wire frame_end = shifter_free && left_r == 4'h1 && !any_load;
    wire [13:0] data_frame = nine_r ? {4'hf, tx_buf_r, 1'b0} : {5'h1f, tx_buf_r[7:0], 1'b0};
    wire tx_on_rise = wr_c2 && !tx_on_r && WDATA[`ASY_C2_TXON];
    wire brk_fall = wr_c2 && brk_req_r && !WDATA[`ASY_C2_BRK];
    wire tx_bit = (left_r != 4'h0) ? shift_r[0] : 1'b1;

    assign TXD_OUT = tx_bit ^ tx_level_invert_r;
    assign TXD_OE_N = !(tx_on_r || left_r != 4'h0 || pend_idle_r || pend_brk_r);

    // Receiver
    wire rx_s = RXD_IN ^ rx_level_invert_r;
    wire rx_tick = sample_tick && rx_on_r;
    wire fall_edge = hist_r == 3'h7 && !rx_s;
    wire [4:0] phase_inc = (phase_r == `ASY_RT16) ? `ASY_RT1 : phase_r + 5'h01;
    wire [1:0] zeros = 2'(!smp_r[0]) + 2'(!smp_r[1]) + 2'(!rx_s);
    wire vote = (smp_r[0] & smp_r[1]) | (smp_r[0] & rx_s) | (smp_r[1] & rx_s);
    wire disagree = (smp_r[0] != vote) || (smp_r[1] != vote) || (rx_s != vote);
    wire [3:0] stop_idx = nine_r ? 4'ha : 4'h9;
    wire at_rt10 = rx_tick && rx_st_r == RX_BITS && !fall_edge && phase_r == `ASY_RT10;
    wire rx_finish = at_rt10 && bitn_r == stop_idx;
    wire [8:0] rx_char = nine_r ? rsh_r : {1'b0, rsh_r[8:1]};
    wire frame_err = !vote;
    wire is_break = frame_err && rx_char == 9'h000;
    wire rx_xfer = rx_finish && !fe_r && !rx_buffer_full_r;
    wire rx_over = rx_finish && !fe_r && rx_buffer_full_r;
    wire clr_rx = rd_data && arm_r;

    wire [7:0] stat_word = 8'({tx_full_r == 1'b0, tc_r, rx_buffer_full_r}) << `ASY_S1_RX_BUFFER_FULL
        | 8'({or_r, nf_r, fe_r}) << `ASY_S1_FE;
    wire [7:0] c1_word = 8'({rx_level_invert_r, tx_level_invert_r, lbrk_r, nine_r});
    wire [7:0] c2_word = 8'({tx_on_r, rx_on_r, 1'b0, brk_req_r});
    wire [7:0] c3_word = 8'({rx_buf_r[8], t8_r}) << `ASY_C3_T8;
    wire [15:0] div_word = 16'(div_r);
    wire [7:0] rd_mux =
        (ADDR == `ASY_OFF_BAUD_HI) ? div_word[15:8] :
        (ADDR == `ASY_OFF_BAUD_LO) ? div_word[7:0] :
        (ADDR == `ASY_OFF_CTRL1) ? c1_word :
        (ADDR == `ASY_OFF_CTRL2) ? c2_word :
        (ADDR == `ASY_OFF_STAT1) ? stat_word :
        (ADDR == `ASY_OFF_CTRL3) ? c3_word :
        (ADDR == `ASY_OFF_DATA) ? rx_buf_r[7:0] : 8'h00;
    assign RDATA = rdata_r;

    // Registers and baud counter
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            div_r <= BAUD_W'(`ASY_BAUD_RST);
            cnt_r <= '0;
            sub_r <= 4'h0;
            {nine_r, lbrk_r, tx_level_invert_r, rx_level_invert_r} <= 4'h0;
            {tx_on_r, rx_on_r, brk_req_r, t8_r} <= 4'h0;
            rdata_r <= 8'h00;
        end else begin
            if (wr_hi) div_r <= BAUD_W'({WDATA, div_word[7:0]});
            else if (wr_lo) div_r <= BAUD_W'({div_word[15:8], WDATA});
            cnt_r <= sample_tick ? div_r : (cnt_r == '0 ? '0 : cnt_r - BAUD_W'(1));
            if (sample_tick) sub_r <= sub_r + 4'h1;
            if (wr_c1) begin
                nine_r <= WDATA[`ASY_C1_NINE];
                lbrk_r <= WDATA[`ASY_C1_LBRK];
                tx_level_invert_r <= WDATA[`ASY_C1_TX_LEVEL_INVERT];
                rx_level_invert_r <= WDATA[`ASY_C1_RX_LEVEL_INVERT];
            end
            if (wr_c2) begin
                tx_on_r <= WDATA[`ASY_C2_TXON];
                rx_on_r <= WDATA[`ASY_C2_RXON];
                brk_req_r <= WDATA[`ASY_C2_BRK];
            end
            if (wr_c3) t8_r <= WDATA[`ASY_C3_T8];
            rdata_r <= RD ? rd_mux : 8'h00;
        end
    end

    // Transmit shifter and queue
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            tx_buf_r <= 9'h000;
            tx_full_r <= 1'b0;
            tc_r <= 1'b1;
            pend_idle_r <= 1'b0;
            pend_brk_r <= 1'b0;
            shift_r <= 14'h3fff;
            left_r <= 4'h0;
        end else begin
            if (wr_data) begin
                tx_buf_r <= {t8_r, WDATA};
                tx_full_r <= 1'b1;
                tc_r <= 1'b0;
            end else if (load_data) begin
                tx_full_r <= 1'b0;
            end
            pend_idle_r <= (pend_idle_r && !load_idle) || tx_on_rise;
            pend_brk_r <= (load_brk ? brk_req_r : pend_brk_r) || brk_fall;
            if (load_idle) begin
                shift_r <= 14'h3fff;
                left_r <= frame_len;
            end else if (load_brk) begin
                shift_r <= 14'h0000;
                left_r <= brk_len;
            end else if (load_data) begin
                shift_r <= data_frame;
                left_r <= frame_len;
            end else if (bit_tick && left_r != 4'h0) begin
                shift_r <= {1'b1, shift_r[13:1]};
                left_r <= left_r - 4'h1;
            end
            if (any_load) tc_r <= 1'b0;
            else if (frame_end) tc_r <= 1'b1;
        end
    end

    // Receive sampling, framing and shift register
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rx_st_r <= RX_HUNT;
            hist_r <= 3'h0;
            phase_r <= `ASY_RT1;
            bitn_r <= 4'h0;
            smp_r <= 2'h0;
            rsh_r <= 9'h000;
            noise_r <= 1'b0;
        end else if (!rx_on_r) begin
            rx_st_r <= RX_HUNT;
            hist_r <= 3'h0;
        end else if (rx_tick) begin
            hist_r <= {hist_r[1:0], rx_s};
            phase_r <= phase_inc;
            case (rx_st_r)
                RX_HUNT: begin
                    if (fall_edge) begin
                        rx_st_r <= RX_START;
                        phase_r <= `ASY_RT1 + 5'h01;
                        noise_r <= 1'b0;
                        bitn_r <= 4'h0;
                    end
                end
                RX_START: begin
                    if (phase_r == `ASY_RT3) smp_r[0] <= rx_s;
                    if (phase_r == `ASY_RT5) smp_r[1] <= rx_s;
                    if (phase_r == `ASY_RT7 && zeros < 2'h2) rx_st_r <= RX_HUNT;
                    if (phase_r == `ASY_RT7 && zeros != 2'h3 && zeros >= 2'h2) noise_r <= 1'b1;
                    if ((phase_r == `ASY_RT8 || phase_r == `ASY_RT9 || phase_r == `ASY_RT10) && rx_s)
                        noise_r <= 1'b1;
                    if (phase_r == `ASY_RT16) begin
                        rx_st_r <= RX_BITS;
                        bitn_r <= 4'h1;
                    end
                end
                RX_BITS: begin
                    if (fall_edge) begin
                        phase_r <= `ASY_RT1 + 5'h01;
                        // An early edge skips the phase-16 step, so count the bit here
                        if (phase_r > `ASY_RT10) bitn_r <= bitn_r + 4'h1;
                    end else begin
                        if (phase_r == `ASY_RT8) smp_r[0] <= rx_s;
                        if (phase_r == `ASY_RT9) smp_r[1] <= rx_s;
                        if (phase_r == `ASY_RT10) begin
                            if (disagree) noise_r <= 1'b1;
                            if (bitn_r == stop_idx) begin
                                rx_st_r <= RX_HUNT;
                                if (frame_err && !is_break) hist_r <= 3'h7;
                            end else begin
                                rsh_r <= {vote, rsh_r[8:1]};
                            end
                        end
                        if (phase_r == `ASY_RT16) bitn_r <= bitn_r + 4'h1;
                    end
                end
                default: rx_st_r <= RX_HUNT;
            endcase
        end
    end

    // Receive buffer and flags; a new character wins over the clearing read
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rx_buf_r <= 9'h000;
            rx_buffer_full_r <= 1'b0;
            or_r <= 1'b0;
            nf_r <= 1'b0;
            fe_r <= 1'b0;
            arm_r <= 1'b0;
        end else begin
            if (rd_stat && rx_buffer_full_r) arm_r <= 1'b1;
            else if (rd_data) arm_r <= 1'b0;
            if (rx_xfer) begin
                rx_buf_r <= rx_char;
                rx_buffer_full_r <= 1'b1;
                nf_r <= noise_r || disagree;
                fe_r <= frame_err;
            end else if (clr_rx) begin
                rx_buffer_full_r <= 1'b0;
                nf_r <= 1'b0;
                fe_r <= 1'b0;
            end
            if (rx_over) or_r <= 1'b1;
            else if (clr_rx) or_r <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    property p_idle_level;
        left_r == 4'h0 |-> TXD_OUT == !tx_level_invert_r;
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
    property p_preamble;
        tx_on_rise |=> pend_idle_r && !TXD_OE_N;
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble not queued");
    property p_load_empty;
        load_data && !wr_data |=> !tx_full_r && left_r == frame_len && shift_r[0] == 1'b0;
    endproperty
    a_load_empty: assert property (p_load_empty) else $error("load did not free buffer");
    property p_done;
        frame_end |=> tc_r && left_r == 4'h0 && TXD_OUT == !tx_level_invert_r;
    endproperty
    a_done: assert property (p_done) else $error("done flag missing");
    property p_hold_pin;
        (left_r != 4'h0 || pend_brk_r) |-> !TXD_OE_N;
    endproperty
    a_hold_pin: assert property (p_hold_pin) else $error("pin released early");
    property p_brk_queue;
        brk_fall |=> pend_brk_r;
    endproperty
    a_brk_queue: assert property (p_brk_queue) else $error("break not queued");
    property p_brk_again;
        load_brk && brk_req_r |=> pend_brk_r && shift_r == 14'h0000;
    endproperty
    a_brk_again: assert property (p_brk_again) else $error("break not requeued");
    property p_brk_len;
        load_brk |=> left_r == (lbrk_r ? (nine_r ? 4'he : 4'hd) : (nine_r ? 4'hb : 4'ha));
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break length wrong");
    property p_start_reject;
        rx_tick && rx_st_r == RX_START && phase_r == `ASY_RT7 && zeros < 2'h2 |=> rx_st_r == RX_HUNT;
    endproperty
    a_start_reject: assert property (p_start_reject) else $error("false start kept");
    property p_overrun;
        rx_over && !clr_rx |=> or_r && rx_buffer_full_r && $stable(rx_buf_r);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_fe_block;
        fe_r && !clr_rx |=> $stable(rx_buf_r);
    endproperty
    a_fe_block: assert property (p_fe_block) else $error("buffer changed under framing error");
    property p_clear;
        rd_stat && rx_buffer_full_r ##1 (rd_data && !rx_xfer) |=> !rx_buffer_full_r;
    endproperty
    a_clear: assert property (p_clear) else $error("receive flag not cleared");

    c_data_load: cover property (load_data);
    c_break_load: cover property (load_brk);
    c_rx_xfer: cover property (rx_xfer);
    c_overrun: cover property (rx_over);
endmodule
`default_nettype wire

// ### asy_defines.svh
// Offsets, field positions, reset values and timing counts of the serial core
`ifndef ASY_DEFINES_SVH
`define ASY_DEFINES_SVH

`define ASY_OFF_BAUD_HI 3'h0
`define ASY_OFF_BAUD_LO 3'h1
`define ASY_OFF_CTRL1 3'h2
`define ASY_OFF_CTRL2 3'h3
`define ASY_OFF_STAT1 3'h4
`define ASY_OFF_CTRL3 3'h5
`define ASY_OFF_DATA 3'h7

`define ASY_C1_NINE 0
`define ASY_C1_LBRK 1
`define ASY_C1_TX_LEVEL_INVERT 2
`define ASY_C1_RX_LEVEL_INVERT 3
`define ASY_C2_BRK 0
`define ASY_C2_RXON 2
`define ASY_C2_TXON 3
`define ASY_C3_T8 6
`define ASY_C3_R8 7
`define ASY_S1_TX_BUFFER_EMPTY 7
`define ASY_S1_TC 6
`define ASY_S1_RX_BUFFER_FULL 5
`define ASY_S1_OR 3
`define ASY_S1_NF 2
`define ASY_S1_FE 1

`define ASY_BAUD_RST 13'h000a

`define ASY_LEN_8 4'ha
`define ASY_LEN_9 4'hb
`define ASY_LEN_LONG_BREAK_SELECT 4'hd
`define ASY_LEN_BRK14 4'he

`define ASY_RT1 5'h01
`define ASY_RT3 5'h03
`define ASY_RT5 5'h05
`define ASY_RT7 5'h07
`define ASY_RT8 5'h08
`define ASY_RT9 5'h09
`define ASY_RT10 5'h0a
`define ASY_RT16 5'h10
`define ASY_SUB_LAST 4'hf

`endif

// ### asy_pkg.sv
// Types shared by the serial core
`default_nettype none
package asy_pkg;
    typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} asy_rx_state_t;
endpackage
`default_nettype wire

// ### asy_remote.sv
// Remote serial node model: sends frames to the core and decodes frames from it
`default_nettype none
module asy_remote #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    input wire logic line_in,
    output var logic line_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx_last;
    logic rx_stop;
    int rx_count = 0;
    initial line_out = 1'b1;
    // Start low, data LSB first, stop level given by caller; idle high after
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            line_out <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
        @(posedge clk);
        line_out <= 1'b1;
    endtask
    // Short low pulse of len cycles, to probe the start check
    task automatic glitch(input int len);
        @(posedge clk);
        line_out <= 1'b0;
        repeat (len) @(posedge clk);
        line_out <= 1'b1;
    endtask
    // Mid-bit sampling of frames from the core
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            rx_last[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge clk);
        rx_stop = line_in;
        rx_count++;
    end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the serial core
`default_nettype none
`include "asy_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [2:0] a; logic [7:0] m; logic [7:0] v;} asy_row_t;
    logic clk_sys, rst, wr_s, rd_s, rxd, txd, txd_oe_n;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    int miscompares = 0;
    int tests_run = 0;
    int seen = 0;
    int n;
    asy_row_t rows[8] = '{'{`ASY_OFF_BAUD_HI, 8'h1f, 8'h00}, '{`ASY_OFF_BAUD_LO, 8'hff, 8'h0a},
        '{`ASY_OFF_CTRL1, 8'h0f, 8'h00}, '{`ASY_OFF_CTRL2, 8'h0d, 8'h00}, '{`ASY_OFF_STAT1, 8'hee, 8'hc0},
        '{`ASY_OFF_CTRL3, 8'hc0, 8'h00}, '{3'h6, 8'hff, 8'h00}, '{`ASY_OFF_DATA, 8'hff, 8'h00}};
    int brk_len[4] = '{10, 11, 13, 14};

    asy_core asy_core_i (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .RXD_IN(rxd), .TXD_OUT(txd), .TXD_OE_N(txd_oe_n));
    // Released pin floats to its pull-up level at the far end
    wire tx_line = txd_oe_n ? 1'b1 : txd;
    asy_remote #(.BIT_CYC(16)) asy_remote_i (.clk(clk_sys), .line_in(tx_line), .line_out(rxd));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_sys);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk_reg(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v, input string what);
        logic [7:0] d;
        rd(a, d);
        chk(d & m, v, what);
    endtask
    task automatic wait_stat(input int b);
        logic [7:0] d;
        int k;
        d = 8'h00;
        k = 0;
        while (d[b] !== 1'b1 && k < 2000) begin
            rd(`ASY_OFF_STAT1, d);
            k++;
        end
        if (d[b] !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t status bit never set", $time);
        end
    endtask
    task automatic expect_rx(input logic [7:0] v);
        int k;
        k = 0;
        while (asy_remote_i.rx_count <= seen && k < 3000) begin
            @(posedge clk_sys);
            k++;
        end
        if (asy_remote_i.rx_count <= seen) begin
            miscompares++;
            $display("[ERR] %0t remote frame missing", $time);
        end
        seen++;
        chk(asy_remote_i.rx_last, v, "remote byte");
        chk({7'h00, asy_remote_i.rx_stop}, 8'h01, "remote stop");
    endtask
    // Waits for the line to reach lvl; n counts the cycles spent
    task automatic wait_txd(input logic lvl, input int lim);
        n = 0;
        while (txd !== lvl && n < lim) begin
            @(posedge clk_sys) #1;
            n++;
        end
        if (txd !== lvl) begin
            miscompares++;
            $display("[ERR] %0t line level not reached", $time);
        end
    endtask
    task automatic low_len();
        wait_txd(1'b0, 2000);
        wait_txd(1'b1, 400);
    endtask

    initial begin
        #(50 * 40000);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        addr = 3'h0;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        rst = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys) #1;
        chk({6'h00, txd, txd_oe_n}, 8'h03, "idle pin after reset");
        foreach (rows[i]) chk_reg(rows[i].a, rows[i].m, rows[i].v, "reset value");
        $display("test reset done");
        wr(`ASY_OFF_BAUD_HI, 8'h00);
        wr(`ASY_OFF_BAUD_LO, 8'h01);
        wr(`ASY_OFF_CTRL2, 8'h0c);
        #1 chk({7'h00, txd_oe_n}, 8'h00, "pin taken on enable");
        seen = asy_remote_i.rx_count;
        wr(`ASY_OFF_DATA, 8'ha5);
        chk_reg(`ASY_OFF_STAT1, 8'h80, 8'h00, "data held during preamble");
        low_len();
        wait_stat(`ASY_S1_TX_BUFFER_EMPTY);
        wr(`ASY_OFF_DATA, 8'h5a);
        expect_rx(8'ha5);
        expect_rx(8'h5a);
        wait_stat(`ASY_S1_TC);
        chk_reg(`ASY_OFF_STAT1, 8'hc0, 8'hc0, "transmit done");
        $display("test transmit done");
        asy_remote_i.send(8'h3c, 1'b1);
        wait_stat(`ASY_S1_RX_BUFFER_FULL);
        chk_reg(`ASY_OFF_STAT1, 8'h2e, 8'h20, "clean receive");
        chk_reg(`ASY_OFF_DATA, 8'hff, 8'h3c, "received byte");
        chk_reg(`ASY_OFF_STAT1, 8'h20, 8'h00, "full flag cleared");
        asy_remote_i.send(8'h11, 1'b1);
        asy_remote_i.send(8'h22, 1'b1);
        repeat (4) @(posedge clk_sys);
        chk_reg(`ASY_OFF_STAT1, 8'h28, 8'h28, "overrun");
        chk_reg(`ASY_OFF_DATA, 8'hff, 8'h11, "first byte kept");
        asy_remote_i.send(8'h55, 1'b0);
        wait_stat(`ASY_S1_RX_BUFFER_FULL);
        chk_reg(`ASY_OFF_STAT1, 8'h02, 8'h02, "framing error");
        chk_reg(`ASY_OFF_DATA, 8'hff, 8'h55, "framed byte");
        wait_stat(`ASY_S1_RX_BUFFER_FULL);
        chk_reg(`ASY_OFF_STAT1, 8'h26, 8'h24, "noisy start after framing error");
        chk_reg(`ASY_OFF_DATA, 8'hff, 8'hff, "ones after false stop");
        asy_remote_i.glitch(2);
        repeat (200) @(posedge clk_sys);
        chk_reg(`ASY_OFF_STAT1, 8'h20, 8'h00, "glitch ignored");
        $display("test receive done");
        for (int m = 0; m < 4; m++) begin
            wr(`ASY_OFF_CTRL1, 8'(m));
            wr(`ASY_OFF_CTRL2, 8'h0d);
            wr(`ASY_OFF_CTRL2, 8'h0c);
            low_len();
            chk(8'(n), 8'(brk_len[m] * 16), "break length");
        end
        wr(`ASY_OFF_CTRL1, 8'h00);
        wr(`ASY_OFF_CTRL2, 8'h0d);
        wr(`ASY_OFF_CTRL2, 8'h0c);
        wait_txd(1'b0, 40);
        wr(`ASY_OFF_CTRL2, 8'h0d);
        wr(`ASY_OFF_CTRL2, 8'h0c);
        wr(`ASY_OFF_CTRL2, 8'h0d);
        repeat (400) @(posedge clk_sys);
        #1 chk({7'h00, txd}, 8'h00, "break repeats while held");
        wr(`ASY_OFF_CTRL2, 8'h0c);
        wait_txd(1'b1, 400);
        $display("test break done");
        seen = asy_remote_i.rx_count;
        wr(`ASY_OFF_DATA, 8'h81);
        wait_txd(1'b0, 400);
        wr(`ASY_OFF_CTRL2, 8'h04);
        #1 chk({7'h00, txd_oe_n}, 8'h00, "pin kept while shifting");
        expect_rx(8'h81);
        repeat (20) @(posedge clk_sys);
        #1 chk({7'h00, txd_oe_n}, 8'h01, "pin released");
        wr(`ASY_OFF_CTRL1, 8'h04);
        #1 chk({7'h00, txd}, 8'h00, "inverted idle");
        $display("test release and invert done");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys) #1;
        chk({6'h00, txd, txd_oe_n}, 8'h03, "idle pin after second reset");
        chk_reg(`ASY_OFF_STAT1, 8'he0, 8'hc0, "flags after second reset");
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
